// >>> logic/dfrc_top.sv
// frequency reference and run command conditioner of a motor drive
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - not retained: setpoint back to preset at stop
// - retained: keep stop setpoint with up/down
// - retention only for digital frequency source
// - hold zero frequency for dead time on reversal
// - carrier setting limited to 0.5..16.0 kHz
// - hot heat sink lowers carrier, then restores
// - ignore run already active at power-on
// - ignore run active at fault reset
// - inching uses its own frequency and ramps
// - inching starts direct, stops by deceleration
// - terminal inch preempts normal run if enabled
// - setpoint in band runs at nearest edge
// - two jump frequencies, both zero disables
// - ramp steps across band in run state when enabled
// - resolution 0.01 Hz or 0.1 Hz, max counts
// - resolution moves decimal point of all frequencies but the carrier
//////////////////////////////////////////////////////////////////////////////
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dfrc_regs.svh"
module dfrc_top #(
	parameter int CYC_PER_DS = `DFRC_CYC_PER_DS, // cycles in 0.1 s
	parameter logic [15:0] CARRIER_DEFAULT = 16'h0028, // model dependent carrier, 0.1 kHz units
	parameter logic [15:0] RAMP_DEFAULT = 16'h00C8 // normal ramp time, 0.1 s units
) (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic RUN_CMD,
	input wire logic INCH_KEY,
	input wire logic INCH_TERM,
	input wire logic DIR_REV,
	input wire logic UP_REQ,
	input wire logic DOWN_REQ,
	input wire logic FAULT_RESET,
	input wire logic HEATSINK_HOT,
	input wire logic [15:0] EXT_FREQ_REF,
	output logic [15:0] OUT_FREQ,
	output logic OUT_REVERSE,
	output logic RUNNING,
	output logic [15:0] CARRIER_FREQ,
	output logic COARSE_RES,
	output logic START_DIRECT,
	output logic STOP_DECEL
);
	//////////////////////////////////////////////////////////////////////////
	// function helpers
	// lower edge of a band, floored at zero
	function automatic logic [15:0] band_lo(input logic [15:0] f, input logic [15:0] a);
		band_lo = (f > a) ? f - a : 16'h0000;
	endfunction
	// upper edge of a band
	function automatic logic [15:0] band_hi(input logic [15:0] f, input logic [15:0] a);
		band_hi = 16'(17'(f) + 17'(a));
	endfunction
	// strictly inside a band of nonzero amplitude
	function automatic logic in_band(input logic [15:0] x, input logic [15:0] f, input logic [15:0] a);
		in_band = (a != 16'h0000) && (f != 16'h0000) && (x > band_lo(f, a)) && (x < band_hi(f, a));
	endfunction
	// inside a band, or resting on the edge that a ramp is about to cross
	function automatic logic band_entry(input logic [15:0] x, input logic [15:0] f, input logic [15:0] a,
		input logic up);
		band_entry = in_band(x, f, a) ||
			(a != 16'h0000 && f != 16'h0000 && x == (up ? band_lo(f, a) : band_hi(f, a)));
	endfunction
	// move a setpoint to the nearer band edge
	function automatic logic [15:0] skip_adj(input logic [15:0] x, input logic [15:0] f, input logic [15:0] a);
		if (in_band(x, f, a)) begin
			skip_adj = (x < f) ? band_lo(f, a) : band_hi(f, a);
		end else begin
			skip_adj = x;
		end
	endfunction
	// clamp to a range
	function automatic logic [15:0] clamp(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
		clamp = (x < lo) ? lo : ((x > hi) ? hi : x);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	dfrc_pkg::dfrc_pins_t pin_raw; // pins as they arrive
	dfrc_pkg::dfrc_pins_t pin_meta; // first stage, read only by second
	dfrc_pkg::dfrc_pins_t pin_s; // synchronised levels
	dfrc_pkg::dfrc_pins_t pin_d; // one cycle older, for edges
	logic [1:0] sync_fill; // high once pin_s holds real pin levels, not reset zeros
	assign pin_raw = '{RUN_CMD, INCH_KEY, INCH_TERM, DIR_REV, UP_REQ, DOWN_REQ, FAULT_RESET, HEATSINK_HOT};
	// two flops then an edge register
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			pin_meta <= '0;
			pin_s <= '0;
			pin_d <= '0;
			sync_fill <= 2'b00;
		end else begin
			pin_meta <= pin_raw;
			pin_s <= pin_meta;
			pin_d <= pin_s;
			sync_fill <= {sync_fill[0], 1'b1};
		end
	end
	wire up_evt = pin_s.up & ~pin_d.up; // one press raises one count
	wire down_evt = pin_s.down & ~pin_d.down;
	wire fault_evt = pin_s.fault_reset & ~pin_d.fault_reset;

	//////////////////////////////////////////////////////////////////////////
	// register file
	logic [15:0] ctrl, preset, dead_time, carrier_set, inch_freq, inch_acc, inch_dec;
	logic [15:0] skip1, skip2, skip_amp, acc_time, dec_time;
	wire wr_preset = WR && ADDR == `DFRC_OFF_PRESET;
	// software writes, low half of the word
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			ctrl <= `DFRC_RST_CTRL;
			preset <= `DFRC_RST_PRESET;
			dead_time <= `DFRC_RST_DEAD;
			carrier_set <= CARRIER_DEFAULT;
			inch_freq <= `DFRC_RST_INCH_FREQ;
			inch_acc <= `DFRC_RST_INCH_TIME;
			inch_dec <= `DFRC_RST_INCH_TIME;
			skip1 <= `DFRC_RST_SKIP;
			skip2 <= `DFRC_RST_SKIP;
			skip_amp <= `DFRC_RST_SKIP;
			acc_time <= RAMP_DEFAULT;
			dec_time <= RAMP_DEFAULT;
		end else if (WR) begin
			unique case (ADDR)
				`DFRC_OFF_CTRL: ctrl <= {7'h00, WDATA[8:0]};
				`DFRC_OFF_PRESET: preset <= clamp(WDATA[15:0], 16'h0000, `DFRC_FREQ_MAX);
				`DFRC_OFF_DEAD: dead_time <= clamp(WDATA[15:0], 16'h0000, `DFRC_DEAD_MAX);
				`DFRC_OFF_CARRIER: carrier_set <= clamp(WDATA[15:0], `DFRC_CARRIER_MIN, `DFRC_CARRIER_MAX);
				`DFRC_OFF_INCH_FREQ: inch_freq <= clamp(WDATA[15:0], 16'h0000, `DFRC_FREQ_MAX);
				`DFRC_OFF_INCH_ACC: inch_acc <= WDATA[15:0];
				`DFRC_OFF_INCH_DEC: inch_dec <= WDATA[15:0];
				`DFRC_OFF_SKIP1: skip1 <= WDATA[15:0];
				`DFRC_OFF_SKIP2: skip2 <= WDATA[15:0];
				`DFRC_OFF_SKIP_AMP: skip_amp <= WDATA[15:0];
				`DFRC_OFF_ACC: acc_time <= WDATA[15:0];
				`DFRC_OFF_DEC: dec_time <= WDATA[15:0];
				default: ; // read-only or unmapped
			endcase
		end
	end
	wire retain = ctrl[`DFRC_BIT_RETAIN];
	wire therm_en = ctrl[`DFRC_BIT_THERM_EN];
	wire protect_en = ctrl[`DFRC_BIT_PROTECT_EN];
	wire inch_prio = ctrl[`DFRC_BIT_INCH_PRIO];
	wire skip_ramp = ctrl[`DFRC_BIT_SKIP_RAMP];
	wire src_digital = ctrl[`DFRC_BIT_SRC_DIGITAL];
	wire stop_coast = ctrl[`DFRC_BIT_STOP_MODE];
	wire start_other = ctrl[`DFRC_BIT_START_MODE];

	//////////////////////////////////////////////////////////////////////////
	// run sequencer
	dfrc_pkg::dfrc_state_t state, next_state;
	logic block; // startup protection latch
	logic inch_last; // last motion was inching
	logic [15:0] dig_set; // digital setpoint with up/down
	logic [31:0] pre_cnt; // cycles within 0.1 s
	logic [15:0] dead_cnt; // elapsed dead time, 0.1 s units
	logic [15:0] ramp_out;
	wire run_ok = pin_s.run & ~(protect_en & block);
	wire inch_req = pin_s.inch_key | pin_s.inch_term;
	wire dead_done = dead_cnt >= dead_time;
	// next state
	always_comb begin
		next_state = state;
		unique case (state)
			dfrc_pkg::ST_IDLE: begin
				if (run_ok) begin
					next_state = dfrc_pkg::ST_RUN;
				end else if (inch_req) begin
					next_state = dfrc_pkg::ST_INCH;
				end
			end
			dfrc_pkg::ST_RUN: begin
				if (!run_ok) begin
					next_state = dfrc_pkg::ST_IDLE;
				end else if (pin_s.inch_term && inch_prio) begin
					next_state = dfrc_pkg::ST_INCH;
				end else if (pin_s.dir_rev != OUT_REVERSE) begin
					next_state = dfrc_pkg::ST_DEAD;
				end
			end
			dfrc_pkg::ST_DEAD: begin
				if (!run_ok) begin
					next_state = dfrc_pkg::ST_IDLE;
				end else if (ramp_out == 16'h0000 && dead_done) begin
					next_state = dfrc_pkg::ST_RUN;
				end
			end
			dfrc_pkg::ST_INCH: begin
				if (!inch_req) begin
					next_state = dfrc_pkg::ST_IDLE;
				end
			end
		endcase
	end
	wire stop_evt = (state == dfrc_pkg::ST_RUN || state == dfrc_pkg::ST_DEAD) && next_state == dfrc_pkg::ST_IDLE;
	wire coast_now = stop_evt && stop_coast; // coast only outside inching
	// state, direction and protection
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			state <= dfrc_pkg::ST_IDLE;
			OUT_REVERSE <= 1'b0;
			block <= 1'b1;
			inch_last <= 1'b0;
		end else begin
			state <= next_state;
			if (state != dfrc_pkg::ST_RUN && next_state == dfrc_pkg::ST_RUN) begin
				OUT_REVERSE <= pin_s.dir_rev;
			end else if (state == dfrc_pkg::ST_IDLE && next_state == dfrc_pkg::ST_INCH) begin
				OUT_REVERSE <= pin_s.dir_rev;
			end
			if (fault_evt && pin_s.run) begin
				block <= 1'b1;
			end else if (!pin_s.run && sync_fill[1]) begin
				block <= 1'b0;
			end
			if (next_state == dfrc_pkg::ST_INCH) begin
				inch_last <= 1'b1;
			end else if (next_state == dfrc_pkg::ST_RUN) begin
				inch_last <= 1'b0;
			end
		end
	end
	// dead time counters, run only at zero output
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			pre_cnt <= 32'h0;
			dead_cnt <= 16'h0000;
		end else if (state != dfrc_pkg::ST_DEAD || ramp_out != 16'h0000) begin
			pre_cnt <= 32'h0;
			dead_cnt <= 16'h0000;
		end else if (pre_cnt >= 32'(CYC_PER_DS - 1)) begin
			pre_cnt <= 32'h0;
			dead_cnt <= dead_done ? dead_cnt : dead_cnt + 16'h0001;
		end else begin
			pre_cnt <= pre_cnt + 32'h1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// digital setpoint
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			dig_set <= `DFRC_RST_PRESET;
		end else if (wr_preset) begin
			dig_set <= clamp(WDATA[15:0], 16'h0000, `DFRC_FREQ_MAX);
		end else if (stop_evt && src_digital && !retain) begin
			dig_set <= preset;
		end else if (up_evt && dig_set < `DFRC_FREQ_MAX) begin
			dig_set <= dig_set + 16'h0001;
		end else if (down_evt && dig_set != 16'h0000) begin
			dig_set <= dig_set - 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// target selection and ramp
	wire [15:0] set_freq = src_digital ? dig_set : clamp(EXT_FREQ_REF, 16'h0000, `DFRC_FREQ_MAX);
	wire [15:0] skipped = skip_adj(skip_adj(set_freq, skip1, skip_amp), skip2, skip_amp);
	logic [15:0] target;
	assign target = (state == dfrc_pkg::ST_INCH) ? inch_freq :
		(state == dfrc_pkg::ST_RUN ? skipped : 16'h0000);
	wire [15:0] t_up = inch_last ? inch_acc : acc_time;
	wire [15:0] t_down = inch_last ? inch_dec : dec_time;
	wire rising = ramp_out < target;
	wire in1 = band_entry(ramp_out, skip1, skip_amp, rising); // jump from the edge, never visit inside while in ST_RUN with skip_ramp set
	wire in2 = band_entry(ramp_out, skip2, skip_amp, rising);
	wire [15:0] cross1 = rising ? band_hi(skip1, skip_amp) : band_lo(skip1, skip_amp);
	wire [15:0] cross2 = rising ? band_hi(skip2, skip_amp) : band_lo(skip2, skip_amp);
	wire jump_now = skip_ramp && state == dfrc_pkg::ST_RUN && ramp_out != target && (in1 || in2);
	wire ramp_load = coast_now || jump_now;
	wire [15:0] load_val = coast_now ? 16'h0000 : (in1 ? cross1 : cross2);
	dfrc_ramp #(.W(16), .CW(32)) u_ramp (
		.clk(SYS_CLK),
		.rst(RESET),
		.target(target),
		.time_up(t_up),
		.time_down(t_down),
		.cyc_per_ds(32'(CYC_PER_DS)),
		.load(ramp_load),
		.load_val(load_val),
		.out(ramp_out)
	);

	//////////////////////////////////////////////////////////////////////////
	// outputs, carrier and readback
	wire [15:0] carrier_low = (carrier_set > `DFRC_CARRIER_MIN + `DFRC_CARRIER_DERATE) ?
		carrier_set - `DFRC_CARRIER_DERATE : `DFRC_CARRIER_MIN;
	wire derate = therm_en & pin_s.hot;
	wire [31:0] status = {10'h000, ctrl[`DFRC_BIT_COARSE_RES], derate, block, OUT_REVERSE, state, ramp_out};
	logic [31:0] rd_mux;
	// read decode
	always_comb begin
		unique case (ADDR)
			`DFRC_OFF_CTRL: rd_mux = {16'h0000, ctrl};
			`DFRC_OFF_PRESET: rd_mux = {16'h0000, preset};
			`DFRC_OFF_DEAD: rd_mux = {16'h0000, dead_time};
			`DFRC_OFF_CARRIER: rd_mux = {16'h0000, carrier_set};
			`DFRC_OFF_INCH_FREQ: rd_mux = {16'h0000, inch_freq};
			`DFRC_OFF_INCH_ACC: rd_mux = {16'h0000, inch_acc};
			`DFRC_OFF_INCH_DEC: rd_mux = {16'h0000, inch_dec};
			`DFRC_OFF_SKIP1: rd_mux = {16'h0000, skip1};
			`DFRC_OFF_SKIP2: rd_mux = {16'h0000, skip2};
			`DFRC_OFF_SKIP_AMP: rd_mux = {16'h0000, skip_amp};
			`DFRC_OFF_ACC: rd_mux = {16'h0000, acc_time};
			`DFRC_OFF_DEC: rd_mux = {16'h0000, dec_time};
			`DFRC_OFF_STATUS: rd_mux = status;
			`DFRC_OFF_SETPOINT: rd_mux = {16'h0000, dig_set};
			default: rd_mux = 32'h0000_0000; // unmapped reads zero
		endcase
	end
	// registered outputs
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 32'h0000_0000;
			CARRIER_FREQ <= CARRIER_DEFAULT;
			RUNNING <= 1'b0;
			START_DIRECT <= 1'b1;
			STOP_DECEL <= 1'b1;
		end else begin
			RDATA <= RD ? rd_mux : 32'h0000_0000;
			CARRIER_FREQ <= derate ? carrier_low : carrier_set;
			RUNNING <= state != dfrc_pkg::ST_IDLE || ramp_out != 16'h0000;
			START_DIRECT <= inch_last | ~start_other;
			STOP_DECEL <= inch_last | ~stop_coast;
		end
	end
	assign OUT_FREQ = ramp_out;
	assign COARSE_RES = ctrl[`DFRC_BIT_COARSE_RES];

	//////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_stop_digital;
		stop_evt && src_digital && !wr_preset;
	endsequence
	a_stop_preset_load: assert property (@(posedge SYS_CLK) disable iff (RESET)
		s_stop_digital and !retain |=> dig_set == $past(preset)) else $error("setpoint not reset at stop");
	a_stop_retain_keep: assert property (@(posedge SYS_CLK) disable iff (RESET)
		s_stop_digital and retain and !up_evt and !down_evt |=> $stable(dig_set)) else $error("setpoint lost");
	a_ext_src_ignore: assert property (@(posedge SYS_CLK) disable iff (RESET)
		stop_evt && !src_digital && !wr_preset && !up_evt && !down_evt |=> $stable(dig_set))
		else $error("retention used off digital source");
	a_dead_zero_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
		state == dfrc_pkg::ST_DEAD && next_state == dfrc_pkg::ST_RUN |-> ramp_out == 16'h0000 && dead_cnt >= dead_time)
		else $error("reversal without dead time");
	a_carrier_range: assert property (@(posedge SYS_CLK) disable iff (RESET)
		CARRIER_FREQ >= `DFRC_CARRIER_MIN && CARRIER_FREQ <= `DFRC_CARRIER_MAX) else $error("carrier out of range");
	a_carrier_derate: assert property (@(posedge SYS_CLK) disable iff (RESET)
		derate ##1 derate |-> CARRIER_FREQ < carrier_set || carrier_set == `DFRC_CARRIER_MIN)
		else $error("carrier not lowered");
	a_protect_block: assert property (@(posedge SYS_CLK) disable iff (RESET)
		protect_en && block && state == dfrc_pkg::ST_IDLE |=> state != dfrc_pkg::ST_RUN) else $error("blocked run started");
	sequence s_fault_with_run;
		fault_evt && pin_s.run && protect_en;
	endsequence
	a_fault_block: assert property (@(posedge SYS_CLK) disable iff (RESET)
		s_fault_with_run |=> block) else $error("fault reset did not block run");
	a_inch_target: assert property (@(posedge SYS_CLK) disable iff (RESET)
		state == dfrc_pkg::ST_INCH |-> target == inch_freq && t_up == inch_acc) else $error("inch reference wrong");
	a_inch_modes: assert property (@(posedge SYS_CLK) disable iff (RESET)
		state == dfrc_pkg::ST_INCH ##1 state == dfrc_pkg::ST_INCH |-> START_DIRECT && STOP_DECEL) else $error("inch mode");
	a_inch_preempt: assert property (@(posedge SYS_CLK) disable iff (RESET)
		state == dfrc_pkg::ST_RUN && run_ok && pin_s.inch_term && inch_prio |=> state == dfrc_pkg::ST_INCH)
		else $error("terminal inch not taken");
	a_skip_outside: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!in_band(skipped, skip1, skip_amp) && !in_band(skipped, skip2, skip_amp)) else $error("target inside band");
	a_freq_limit: assert property (@(posedge SYS_CLK) disable iff (RESET)
		OUT_FREQ <= `DFRC_FREQ_MAX) else $error("output above maximum");
endmodule // dfrc_top
`default_nettype wire

// >>> logic/dfrc_regs.svh
// register offsets, field positions, reset values and timing counts of the frequency conditioner
`ifndef DFRC_REGS_SVH
`define DFRC_REGS_SVH
`define DFRC_OFF_CTRL 8'h00
`define DFRC_OFF_PRESET 8'h04
`define DFRC_OFF_DEAD 8'h08
`define DFRC_OFF_CARRIER 8'h0C
`define DFRC_OFF_INCH_FREQ 8'h10
`define DFRC_OFF_INCH_ACC 8'h14
`define DFRC_OFF_INCH_DEC 8'h18
`define DFRC_OFF_SKIP1 8'h1C
`define DFRC_OFF_SKIP2 8'h20
`define DFRC_OFF_SKIP_AMP 8'h24
`define DFRC_OFF_ACC 8'h28
`define DFRC_OFF_DEC 8'h2C
`define DFRC_OFF_STATUS 8'h30
`define DFRC_OFF_SETPOINT 8'h34
`define DFRC_BIT_RETAIN 0
`define DFRC_BIT_THERM_EN 1
`define DFRC_BIT_PROTECT_EN 2
`define DFRC_BIT_INCH_PRIO 3
`define DFRC_BIT_SKIP_RAMP 4
`define DFRC_BIT_COARSE_RES 5
`define DFRC_BIT_SRC_DIGITAL 6
`define DFRC_BIT_START_MODE 7
`define DFRC_BIT_STOP_MODE 8
`define DFRC_RST_CTRL 16'h0042
`define DFRC_RST_PRESET 16'h0000
`define DFRC_RST_DEAD 16'h0000
`define DFRC_RST_INCH_FREQ 16'h00C8
`define DFRC_RST_INCH_TIME 16'h00C8
`define DFRC_RST_SKIP 16'h0000
`define DFRC_FREQ_MAX 16'h7D00
`define DFRC_DEAD_MAX 16'h7530
`define DFRC_CARRIER_MIN 16'h0005
`define DFRC_CARRIER_MAX 16'h00A0
`define DFRC_CARRIER_DERATE 16'h0014
`define DFRC_CLK_NS 8
`define DFRC_DS_NS 100000000
`define DFRC_CYC_PER_DS (`DFRC_DS_NS / `DFRC_CLK_NS)
`endif

// >>> logic/dfrc_pkg.sv
// types shared by the frequency conditioner files
`default_nettype none
package dfrc_pkg;
	// operating states of the run sequencer
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_INCH, ST_DEAD} dfrc_state_t;
	// synchronised command pins
	typedef struct packed {
		logic run;
		logic inch_key;
		logic inch_term;
		logic dir_rev;
		logic up;
		logic down;
		logic fault_reset;
		logic hot;
	} dfrc_pins_t;
endpackage
`default_nettype wire

// >>> logic/dfrc_ramp.sv
// linear ramp generator, one count per step, time base is the maximum frequency
`timescale 1ns/1ns
`default_nettype none
`include "dfrc_regs.svh"
module dfrc_ramp #(
	parameter int W = 16,
	parameter int CW = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] target,
	input wire logic [W-1:0] time_up,
	input wire logic [W-1:0] time_down,
	input wire logic [CW-1:0] cyc_per_ds,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] out
);
	localparam logic [47:0] FULL = 48'(`DFRC_FREQ_MAX); // added every cycle
	logic [47:0] acc; // fractional step accumulator
	wire rising = out < target;
	wire [W-1:0] tsel = rising ? time_up : time_down;
	wire [47:0] thr = 48'(tsel) * 48'(cyc_per_ds); // full-scale ramp length in cycles
	wire [47:0] sum = acc + FULL;
	wire step = (out != target) && (sum >= thr);
	wire [47:0] next_acc = (out == target || thr == 48'h0) ? 48'h0 : (step ? sum - thr : sum);
	wire [W-1:0] next_out = load ? load_val : (step ? (rising ? out + W'(1) : out - W'(1)) : out);
	// accumulator and output step
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= 48'h0;
			out <= '0;
		end else begin
			acc <= load ? 48'h0 : next_acc;
			out <= next_out;
		end
	end
endmodule // dfrc_ramp
`default_nettype wire

// >>> sim/dfrc_partner.sv
// command source model: keypad, terminals and run sources as synchronous levels
`timescale 1ns/1ns
`default_nettype none
module dfrc_partner (
	input wire logic clk,
	input wire logic slow,
	input wire dfrc_pkg::dfrc_pins_t req,
	output var dfrc_pkg::dfrc_pins_t pins
);
	dfrc_pkg::dfrc_pins_t stage = '0; // extra stage for a slow answer
	initial pins = '0;
	////////////////////////////////////////////////////////////////////////////
	// levels change only after a clock edge, promptly or one edge late
	always @(posedge clk) begin
		stage <= req;
		pins <= slow ? stage : req;
	end
endmodule // dfrc_partner
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench of the frequency reference conditioner
`timescale 1ns/1ns
`default_nettype none
`include "dfrc_regs.svh"
module tb_top;
	logic clk = 1'b0; // system clock
	logic rst = 1'b1; // reset, active high
	logic [7:0] addr = 8'h00; // bus address
	logic [31:0] wdata = 32'h0; // bus write data
	logic wr = 1'b0; // write strobe
	logic rd = 1'b0; // read strobe
	logic slow = 1'b0; // partner speed
	logic [15:0] ext_ref = 16'h0000; // external reference
	dfrc_pkg::dfrc_pins_t req = '0; // pin levels asked of partner
	dfrc_pkg::dfrc_pins_t pins; // pin levels from partner
	logic [31:0] rdata, d;
	logic [15:0] out_freq, carrier, sp;
	logic out_rev, running, coarse, st_dir, sp_dec;
	int failures = 0;
	int num_checks = 0;
	int i;
	int hits; // samples seen inside a jump band
	always #4 clk = ~clk;
	dfrc_partner partner (.clk(clk), .slow(slow), .req(req), .pins(pins));
	dfrc_top #(.CYC_PER_DS(10)) uut (.SYS_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .RUN_CMD(pins.run), .INCH_KEY(pins.inch_key), .INCH_TERM(pins.inch_term),
		.DIR_REV(pins.dir_rev), .UP_REQ(pins.up), .DOWN_REQ(pins.down), .FAULT_RESET(pins.fault_reset),
		.HEATSINK_HOT(pins.hot), .EXT_FREQ_REF(ext_ref), .OUT_FREQ(out_freq), .OUT_REVERSE(out_rev),
		.RUNNING(running), .CARRIER_FREQ(carrier), .COARSE_RES(coarse), .START_DIRECT(st_dir),
		.STOP_DECEL(sp_dec));
	////////////////////////////////////////////////////////////////////////////
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// one-cycle bus write
	task bus_wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= {16'h0, v};
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// one-cycle bus read, data taken in the following cycle
	task bus_rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded wait for an output frequency, a timeout ends the run
	task wait_out(input logic [15:0] e);
		for (i = 0; i < 4000 && out_freq !== e; i++) @(negedge clk);
		chk(out_freq, e);
		if (out_freq !== e) results();
	endtask
	// hold a pin level for some cycles
	task hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// expected running frequency with two open bands around their centres
	function automatic logic [15:0] skip_exp(input logic [15:0] s, input logic [15:0] c1, input logic [15:0] c2,
		input logic [15:0] amp);
		logic [15:0] c;
		c = (s > c1 - amp && s < c1 + amp) ? c1 : c2;
		if (amp == 16'h0 || c == 16'h0 || !(s > c - amp && s < c + amp)) return s;
		return (s - (c - amp) < (c + amp) - s) ? c - amp : c + amp;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'h3EBE));
		hold(2);
		req.run <= 1'b1;
		hold(10);
		rst <= 1'b0;
		addr <= `DFRC_OFF_CTRL;
		wdata <= 32'h46;
		wr <= 1'b1;
		@(posedge clk) wr <= 1'b0;
		#1 chk({carrier, coarse, st_dir, sp_dec}, {16'h28, 3'b011});
		bus_rd(`DFRC_OFF_INCH_FREQ);
		chk(d, 32'hC8);
		bus_rd(`DFRC_OFF_INCH_DEC);
		chk(d, 32'hC8);
		bus_rd(8'h3C);
		chk(d, 32'h0);
		bus_wr(`DFRC_OFF_ACC, 16'h0);
		bus_wr(`DFRC_OFF_DEC, 16'h0);
		hold(40);
		bus_rd(`DFRC_OFF_STATUS);
		chk({d[19], running}, 2'b10);
		req.run <= 1'b0;
		hold(6);
		req.run <= 1'b1;
		for (i = 0; i < 50 && running !== 1'b1; i++) @(negedge clk);
		chk(running, 1'b1);
		if (running !== 1'b1) results();
		bus_wr(`DFRC_OFF_PRESET, 16'd300);
		wait_out(16'd300);
		req.fault_reset <= 1'b1;
		hold(4);
		req.fault_reset <= 1'b0;
		wait_out(16'h0);
		bus_rd(`DFRC_OFF_STATUS);
		chk(d[19:16], 4'h8);
		req.run <= 1'b0;
		hold(6);
		bus_rd(`DFRC_OFF_STATUS);
		chk(d[19], 1'b0);
		$display("power-on and fault-reset protection done");
		for (int k = 0; k < 2; k++) begin
			bus_wr(`DFRC_OFF_CTRL, 16'(16'h46 | k));
			bus_wr(`DFRC_OFF_PRESET, 16'd300);
			repeat (3 - k) begin
				req.up <= 1'b1;
				hold(4);
				req.up <= 1'b0;
				hold(4);
			end
			req.run <= 1'b1;
			wait_out(16'(16'd303 - k));
			req.run <= 1'b0;
			wait_out(16'h0);
			hold(4);
			bus_rd(`DFRC_OFF_SETPOINT);
			chk(d, k ? 32'd302 : 32'd300);
		end
		bus_wr(`DFRC_OFF_CTRL, 16'h06);
		sp = 16'($urandom_range(1000, 1));
		ext_ref <= sp;
		req.run <= 1'b1;
		wait_out(sp);
		req.run <= 1'b0;
		wait_out(16'h0);
		bus_rd(`DFRC_OFF_SETPOINT);
		chk(d, 32'd302);
		$display("setpoint retention done");
		bus_wr(`DFRC_OFF_CTRL, 16'h46);
		bus_wr(`DFRC_OFF_SKIP1, 16'd500);
		bus_wr(`DFRC_OFF_SKIP2, 16'd800);
		bus_wr(`DFRC_OFF_SKIP_AMP, 16'd50);
		req.run <= 1'b1;
		for (int k = 0; k < 10; k++) begin
			sp = k < 5 ? (k == 0 ? 16'd520 : k == 1 ? 16'd470 : k == 2 ? 16'd550 : k == 3 ? 16'd451 : 16'd790)
				: 16'($urandom_range(1000, 1));
			if (sp == 16'd500 || sp == 16'd800) sp++;
			slow <= 1'($urandom_range(1, 0));
			bus_wr(`DFRC_OFF_PRESET, sp);
			wait_out(skip_exp(sp, 16'd500, 16'd800, 16'd50));
		end
		// ramps across a band must never show a value inside it
		bus_wr(`DFRC_OFF_CTRL, 16'h56);
		for (int k = 0; k < 3; k++) begin
			hits = 0;
			sp = (k == 1) ? 16'd700 : 16'd300;
			bus_wr(`DFRC_OFF_PRESET, sp);
			for (i = 0; i < 2000 && out_freq !== sp; i++) begin
				@(negedge clk);
				if (out_freq > 16'd450 && out_freq < 16'd550) hits++;
			end
			chk(hits, 0);
			wait_out(sp);
		end
		bus_wr(`DFRC_OFF_SKIP1, 16'h0);
		bus_wr(`DFRC_OFF_SKIP2, 16'h0);
		bus_wr(`DFRC_OFF_PRESET, 16'd30);
		wait_out(16'd30);
		$display("jump bands done");
		bus_wr(`DFRC_OFF_DEAD, 16'd3);
		bus_wr(`DFRC_OFF_PRESET, 16'd100);
		wait_out(16'd100);
		req.dir_rev <= 1'b1;
		wait_out(16'h0);
		for (i = 0; i < 200 && out_freq === 16'h0; i++) @(negedge clk);
		chk(i >= 30 && i <= 34, 1'b1);
		if (i >= 200) results();
		chk(out_rev, 1'b1);
		for (int k = 0; k < 2; k++) begin
			bus_wr(`DFRC_OFF_CTRL, k ? 16'h46 : 16'h4E);
			req.inch_term <= 1'b1;
			hold(8);
			bus_rd(`DFRC_OFF_STATUS);
			chk(d[17:16], k ? 2'd1 : 2'd2);
			req.inch_term <= 1'b0;
			hold(8);
		end
		req.run <= 1'b0;
		wait_out(16'h0);
		bus_wr(`DFRC_OFF_CTRL, 16'h1C6);
		hold(3);
		chk(st_dir, 1'b0);
		req.inch_key <= 1'b1;
		wait_out(16'hC8);
		chk({st_dir, sp_dec}, 2'b11);
		req.inch_key <= 1'b0;
		hold(4);
		chk(out_freq != 16'h0, 1'b1);
		wait_out(16'h0);
		// same coast setting outside inching drops the output at once
		req.run <= 1'b1;
		wait_out(16'd100);
		req.run <= 1'b0;
		hold(8);
		chk(out_freq, 16'h0);
		$display("reversal and inching done");
		bus_wr(`DFRC_OFF_CARRIER, 16'h1);
		bus_rd(`DFRC_OFF_CARRIER);
		chk(d, 32'h5);
		bus_wr(`DFRC_OFF_CARRIER, 16'hC8);
		bus_rd(`DFRC_OFF_CARRIER);
		chk(d, 32'hA0);
		bus_wr(`DFRC_OFF_CARRIER, 16'h50);
		for (int k = 0; k < 2; k++) begin
			bus_wr(`DFRC_OFF_CTRL, k ? 16'h44 : 16'h46);
			req.hot <= 1'b1;
			hold(8);
			chk(carrier, k ? 16'h50 : 16'h3C);
			req.hot <= 1'b0;
			hold(8);
			chk(carrier, 16'h50);
		end
		bus_wr(`DFRC_OFF_CTRL, 16'h66);
		hold(2);
		chk(coarse, 1'b1);
		bus_rd(`DFRC_OFF_INCH_FREQ);
		chk(d, 32'hC8);
		$display("carrier and resolution done");
		results();
	end
endmodule // tb_top
`default_nettype wire
